/* File: tsa_assigner.sv */
// Time slot assigner: serial control load, slot counters, strobes
module tsa_assigner (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Mode: high is mode 1, low is mode 2
  input wire logic mode1_i,
  // Serial control port, all pins
  input wire logic control_serial_in_i,
  input wire logic control_shift_clock_i,
  input wire logic load_select_n_i,
  input wire logic channel_sel_bit0_i,
  input wire logic channel_sel_bit1_i,
  input wire logic channel_sel_bit2_i,
  // Frame timing pins
  input wire logic bit_clock_i,
  input wire logic transmit_frame_start_i,
  input wire logic receive_frame_start_i,
  // Strobes
  output logic [3:0] transmit_slot_strobe_o,
  output logic [3:0] receive_slot_strobe_o,
  // Open-drain slot active: output always low, enable pulls
  output logic slot_active_n_o,
  output logic slot_active_n_oe_o
);

  // ******************************
  // Input synchronisers
  // ******************************
  localparam int NSYNC = 9;
  logic [NSYNC-1:0] sync1, sync2, prev;
  logic [NSYNC-1:0] next_sync1, next_sync2, next_prev;
  logic [NSYNC-1:0] pins;
  assign pins = {mode1_i, control_serial_in_i, control_shift_clock_i,
    load_select_n_i, channel_sel_bit2_i, channel_sel_bit1_i,
    channel_sel_bit0_i, transmit_frame_start_i, receive_frame_start_i};
  // Pin order in the vectors
  localparam int P_MODE = 8, P_DIN = 7, P_CCLK = 6, P_SEL = 5, P_CH2 = 4;
  localparam int P_CH1 = 3, P_CH0 = 2, P_XS = 1, P_RS = 0;
  // Select and control clock idle high: reset to that level so the
  // release of reset shows no false select rise or clock fall
  localparam logic [NSYNC-1:0] SYNC_IDLE =
    NSYNC'((1 << P_SEL) | (1 << P_CCLK));

  logic bclk_s1, bclk_s2, bclk_prev, next_bclk_s1, next_bclk_s2;
  logic next_bclk_prev;

  always_comb begin
    next_sync1 = pins;
    next_sync2 = sync1;
    next_prev = sync2;
    next_bclk_s1 = bit_clock_i;
    next_bclk_s2 = bclk_s1;
    next_bclk_prev = bclk_s2;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1 <= SYNC_IDLE;
      sync2 <= SYNC_IDLE;
      prev <= SYNC_IDLE;
      bclk_s1 <= 1'b0;
      bclk_s2 <= 1'b0;
      bclk_prev <= 1'b0;
    end else if (ce_i) begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      prev <= next_prev;
      bclk_s1 <= next_bclk_s1;
      bclk_s2 <= next_bclk_s2;
      bclk_prev <= next_bclk_prev;
    end
  end

  logic bclk_fall, cclk_fall, sel_rise, mode1;
  assign bclk_fall = bclk_prev & ~bclk_s2;
  assign cclk_fall = prev[P_CCLK] & ~sync2[P_CCLK];
  assign sel_rise = ~prev[P_SEL] & sync2[P_SEL];
  assign mode1 = sync2[P_MODE];
  // Frame starts count on their rising edge only
  logic xs_rise, rs_rise;
  assign xs_rise = ~prev[P_XS] & sync2[P_XS];
  assign rs_rise = ~prev[P_RS] & sync2[P_RS];

  // ******************************
  // Serial load and assignment registers
  // ******************************
  logic [7:0] shreg, next_shreg;
  logic [5:0] tx_asg [4], rx_asg [4];
  logic [5:0] next_tx_asg [4], next_rx_asg [4];
  logic [1:0] act;
  logic [2:0] chan;
  logic do_tx, do_rx;
  assign act = {shreg[tsa_pkg::ACT_TX_POS], shreg[tsa_pkg::ACT_RX_POS]};
  assign chan = {sync2[P_CH2], sync2[P_CH1], sync2[P_CH0]};

  always_comb begin
    next_shreg = shreg;
    // Shift only while select is low, first bit ends at the top
    if (cclk_fall && !sync2[P_SEL]) begin
      next_shreg = {shreg[6:0], sync2[P_DIN]};
    end
    next_tx_asg = tx_asg;
    next_rx_asg = rx_asg;
    do_tx = 1'b0;
    do_rx = 1'b0;
    if (sel_rise) begin
      if (mode1) begin
        do_tx = (act == tsa_pkg::ACT_BOTH) || (act == tsa_pkg::ACT_TX)
          || (act == tsa_pkg::ACT_OFF);
        do_rx = (act == tsa_pkg::ACT_BOTH) || (act == tsa_pkg::ACT_RX)
          || (act == tsa_pkg::ACT_OFF);
      end else begin
        do_tx = !chan[tsa_pkg::SEL_RX_POS];
        do_rx = chan[tsa_pkg::SEL_RX_POS];
      end
      // Disable is stored as SLOT_OFF, whose set top bit keeps it from ever matching
      if (do_tx) begin
        next_tx_asg[chan[1:0]] = (act == tsa_pkg::ACT_OFF) ?
          tsa_pkg::SLOT_OFF : shreg[5:0];
      end
      if (do_rx) begin
        next_rx_asg[chan[1:0]] = (act == tsa_pkg::ACT_OFF) ?
          tsa_pkg::SLOT_OFF : shreg[5:0];
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      shreg <= '0;
      for (int i = 0; i < tsa_pkg::CHAN_COUNT; i++) begin
        tx_asg[i] <= tsa_pkg::SLOT_OFF;
        rx_asg[i] <= tsa_pkg::SLOT_OFF;
      end
    end else if (ce_i) begin
      shreg <= next_shreg;
      tx_asg <= next_tx_asg;
      rx_asg <= next_rx_asg;
    end
  end

  // ******************************
  // Slot counters and strobes
  // ******************************
  // Slot counters saturate so slots past the frame length never match
  logic [5:0] tx_slot, rx_slot, next_tx_slot, next_rx_slot;
  logic [2:0] tx_bit, rx_bit, next_tx_bit, next_rx_bit;
  logic tx_run, rx_run, next_tx_run, next_rx_run;
  logic tx_arm, rx_arm, next_tx_arm, next_rx_arm;
  logic [3:0] next_fsx, next_fsr;
  logic next_act_oe;

  function automatic logic [3:0] match(input logic [5:0] slot,
      input logic [5:0] asg0, input logic [5:0] asg1,
      input logic [5:0] asg2, input logic [5:0] asg3);
    logic [3:0] m;
    m[0] = !asg0[tsa_pkg::DISABLE_POS] && (asg0 == slot);
    m[1] = !asg1[tsa_pkg::DISABLE_POS] && (asg1 == slot);
    m[2] = !asg2[tsa_pkg::DISABLE_POS] && (asg2 == slot);
    m[3] = !asg3[tsa_pkg::DISABLE_POS] && (asg3 == slot);
    return m;
  endfunction

  always_comb begin
    next_tx_slot = tx_slot;
    next_rx_slot = rx_slot;
    next_tx_bit = tx_bit;
    next_rx_bit = rx_bit;
    next_tx_run = tx_run;
    next_rx_run = rx_run;
    // Arm on a rising frame start, act on the next falling bit clock;
    // a start held across that fall must not restart the count again
    next_tx_arm = tx_arm | xs_rise;
    next_rx_arm = rx_arm | rs_rise;
    next_fsx = transmit_slot_strobe_o;
    next_fsr = receive_slot_strobe_o;
    if (bclk_fall) begin
      if (tx_arm || xs_rise) begin
        next_tx_slot = '0;
        next_tx_bit = '0;
        next_tx_run = 1'b1;
        next_tx_arm = 1'b0;
      end else if (tx_run) begin
        next_tx_bit = tx_bit + 3'h1;
        if (tx_bit == tsa_pkg::BIT_LAST && tx_slot != tsa_pkg::SLOT_MAX) begin
          next_tx_slot = tx_slot + 6'h01;
        end
      end
      if (rx_arm || rs_rise) begin
        next_rx_slot = '0;
        next_rx_bit = '0;
        next_rx_run = 1'b1;
        next_rx_arm = 1'b0;
      end else if (rx_run) begin
        next_rx_bit = rx_bit + 3'h1;
        if (rx_bit == tsa_pkg::BIT_LAST && rx_slot != tsa_pkg::SLOT_MAX) begin
          next_rx_slot = rx_slot + 6'h01;
        end
      end
      // Strobes change only at slot boundaries, so a new load waits
      // for the next whole slot
      if (next_tx_bit == '0) begin
        next_fsx = next_tx_run ? match(next_tx_slot, tx_asg[0],
          tx_asg[1], tx_asg[2], tx_asg[3]) : 4'h0;
      end
      // Mode 2 times every strobe from the transmit frame
      if ((mode1 ? next_rx_bit : next_tx_bit) == '0) begin
        if (mode1) begin
          next_fsr = next_rx_run ? match(next_rx_slot, rx_asg[0],
            rx_asg[1], rx_asg[2], rx_asg[3]) : 4'h0;
        end else begin
          next_fsr = next_tx_run ? match(next_tx_slot, rx_asg[0],
            rx_asg[1], rx_asg[2], rx_asg[3]) : 4'h0;
        end
      end
    end
    next_act_oe = (|next_fsx) || (!mode1 && (|next_fsr));
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_slot <= '0;
      rx_slot <= '0;
      tx_bit <= '0;
      rx_bit <= '0;
      tx_run <= 1'b0;
      rx_run <= 1'b0;
      tx_arm <= 1'b0;
      rx_arm <= 1'b0;
      transmit_slot_strobe_o <= '0;
      receive_slot_strobe_o <= '0;
      slot_active_n_oe_o <= 1'b0;
      slot_active_n_o <= 1'b0;
    end else if (ce_i) begin
      tx_slot <= next_tx_slot;
      rx_slot <= next_rx_slot;
      tx_bit <= next_tx_bit;
      rx_bit <= next_rx_bit;
      tx_run <= next_tx_run;
      rx_run <= next_rx_run;
      tx_arm <= next_tx_arm;
      rx_arm <= next_rx_arm;
      transmit_slot_strobe_o <= next_fsx;
      receive_slot_strobe_o <= next_fsr;
      slot_active_n_oe_o <= next_act_oe;
      slot_active_n_o <= 1'b0;
    end
  end

  // ******************************
  // Checks
  // ******************************
  sequence fall_s;
    bclk_fall && ce_i;
  endsequence

  strobe_edge_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(transmit_slot_strobe_o[0]) |-> $past(bclk_fall))
    else $error("transmit strobe rose away from bit clock fall");
  disabled_slot_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(transmit_slot_strobe_o[0])
    |-> !$past(tx_asg[0][tsa_pkg::DISABLE_POS]))
    else $error("strobe active on disabled slot");
  frame_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (fall_s ##0 (tx_arm || xs_rise)) |=> (tx_slot == '0 && tx_bit == '0))
    else $error("transmit counter not zeroed at frame start");
  active_pull_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (|transmit_slot_strobe_o) |-> slot_active_n_oe_o)
    else $error("slot active not pulled with strobe");
  mode2_rx_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && sel_rise && !mode1 && chan[2] && act != tsa_pkg::ACT_OFF)
    |=> rx_asg[$past(chan[1:0])] == $past(shreg[5:0]))
    else $error("mode 2 receive select not loaded");
  off_load_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && sel_rise && act == tsa_pkg::ACT_OFF && !mode1 && !chan[2])
    |=> tx_asg[$past(chan[1:0])] == tsa_pkg::SLOT_OFF)
    else $error("disable action did not disable");
  mode1_tx_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && sel_rise && mode1 && act == tsa_pkg::ACT_RX)
    |=> tx_asg[$past(chan[1:0])] == $past(tx_asg[chan[1:0]]))
    else $error("receive-only action changed transmit");
  shift_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && sync2[P_SEL] && !sel_rise) |=> $stable(shreg))
    else $error("shift while select high");
  slot_step_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && bclk_fall && tx_bit != tsa_pkg::BIT_LAST && !xs_rise
    && !tx_arm)
    |=> $stable(transmit_slot_strobe_o))
    else $error("strobe changed mid slot");
endmodule

/* File: tsa_pkg.sv */
// Constants for the time slot assigner
//
// Contract
// - Slot field top bit set keeps strobe inactive
// - Mode 2: action 11 disables, else assigns
// - Mode 2: three-bit select, top bit receive
// - Strobes rise on falling bit clock edge
// - Select rising edge loads, next whole slot
// - Counter zeroes at frame start, steps every 8
// - Slot-active pulls low on active strobes; receive strobes pull it in mode 2 only
package tsa_pkg;
  localparam int WORD_BITS = 8;
  localparam int SLOT_BITS = 6;
  localparam int CHAN_COUNT = 4;
  localparam int BITS_PER_SLOT = 8;
  localparam int DISABLE_POS = 5;
  localparam int ACT_RX_POS = 6;
  localparam int ACT_TX_POS = 7;
  localparam int SEL_RX_POS = 2;
  localparam logic [5:0] SLOT_OFF = 6'h20;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [5:0] SLOT_MAX = 6'h3f;
  localparam logic [1:0] ACT_BOTH = 2'h0;
  localparam logic [1:0] ACT_TX = 2'h1;
  localparam logic [1:0] ACT_RX = 2'h2;
  localparam logic [1:0] ACT_OFF = 2'h3;
endpackage

/* File: tsa_host_model.sv */
// Host controller model that shifts assignment words into the block
module tsa_host_model (
  // Clock
  input wire logic mclk_i,
  // Serial control pins
  output logic control_serial_in_o,
  output logic control_shift_clock_o,
  output logic load_select_n_o,
  output logic [2:0] channel_sel_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    control_serial_in_o = 1'b0;
    control_shift_clock_o = 1'b1;
    load_select_n_o = 1'b1;
    channel_sel_o = 3'h0;
  end
  // Every level is held long enough for the pin synchronisers
  task automatic hold_pins();
    repeat (6) @(negedge mclk_i);
  endtask
  task automatic send(input logic [7:0] w, input logic [2:0] chan);
    channel_sel_o = chan;
    load_select_n_o = 1'b0;
    hold_pins();
    for (int i = 7; i >= 0; i--) begin
      control_serial_in_o = w[i];
      hold_pins();
      control_shift_clock_o = 1'b0;
      hold_pins();
      control_shift_clock_o = 1'b1;
      hold_pins();
    end
    load_select_n_o = 1'b1;
    hold_pins();
    // Released lines change, so a stale value is never mistaken for data
    control_serial_in_o = ~control_serial_in_o;
    channel_sel_o = ~channel_sel_o;
    hold_pins();
  endtask
endmodule

/* File: time_slot_assigner_test.sv */
// Self-checking testbench for the time slot assigner
module time_slot_assigner_test;
  timeunit 1ns;
  timeprecision 100ps;
  // ********************************
  // Stimulus, expectations and checks
  // ********************************
  logic mclk, rst, mode1, bit_clock, tx_frame, rx_frame;
  logic ser, sck, sel_n, act_n, act_oe;
  logic [2:0] chan, ch;
  logic [3:0] tx_strobe, rx_strobe;
  logic [5:0] asg_tx [4];
  logic [5:0] asg_rx [4];
  logic [8:0] exp_q [$];
  logic [16:0] lfsr = 17'h1_47c9;
  logic [7:0] r;
  logic [1:0] act;
  int error_cnt = 0;
  int tests_run = 0;
  // Pulled-up wired-AND level of the slot-active line
  wire logic slot_active_n = act_oe ? act_n : 1'b1;
  tsa_host_model i_host (.mclk_i(mclk), .control_serial_in_o(ser),
    .control_shift_clock_o(sck), .load_select_n_o(sel_n),
    .channel_sel_o(chan));
  tsa_assigner i_dut (.mclk_i(mclk), .rst_i(rst), .ce_i(1'b1),
    .mode1_i(mode1), .control_serial_in_i(ser),
    .control_shift_clock_i(sck), .load_select_n_i(sel_n),
    .channel_sel_bit0_i(chan[0]), .channel_sel_bit1_i(chan[1]),
    .channel_sel_bit2_i(chan[2]), .bit_clock_i(bit_clock),
    .transmit_frame_start_i(tx_frame), .receive_frame_start_i(rx_frame),
    .transmit_slot_strobe_o(tx_strobe), .receive_slot_strobe_o(rx_strobe),
    .slot_active_n_o(act_n), .slot_active_n_oe_o(act_oe));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic check(input logic [8:0] seen, input logic [8:0] want);
    tests_run++;
    if (seen !== want) begin
      error_cnt++;
      $display("BAD %0t strobes %h expected %h", $time, seen, want);
    end
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  function automatic logic [8:0] expect_at(input int slot);
    logic [3:0] t, q;
    for (int i = 0; i < 4; i++) begin
      t[i] = !asg_tx[i][5] && asg_tx[i][4:0] == slot[4:0];
      q[i] = !asg_rx[i][5] && asg_rx[i][4:0] == slot[4:0];
    end
    return {!((|t) || (!mode1 && (|q))), q, t};
  endfunction
  function automatic logic [16:0] lfsr_step(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic load(input logic [7:0] w, input logic [2:0] c);
    logic [5:0] v;
    v = (w[7:6] == tsa_pkg::ACT_OFF) ? tsa_pkg::SLOT_OFF : w[5:0];
    i_host.send(w, c);
    if (!mode1) begin
      if (c[tsa_pkg::SEL_RX_POS]) asg_rx[c[1:0]] = v;
      else asg_tx[c[1:0]] = v;
    end else begin
      if (w[7:6] != tsa_pkg::ACT_RX) asg_tx[c[1:0]] = v;
      if (w[7:6] != tsa_pkg::ACT_TX) asg_rx[c[1:0]] = v;
    end
  endtask
  // One frame of 8 slots; the bit clock stands still between frames
  task automatic frame();
    for (int k = 0; k < 64; k++) begin
      bit_clock = 1'b1;
      repeat (4) @(negedge mclk);
      if (k == 0) begin
        tx_frame = 1'b1;
        rx_frame = mode1;
      end
      repeat (4) @(negedge mclk);
      bit_clock = 1'b0;
      exp_q.push_back(expect_at(k / 8));
      repeat (6) @(negedge mclk);
      tx_frame = 1'b0;
      rx_frame = 1'b0;
      repeat (2) @(negedge mclk);
    end
    bit_clock = 1'b1;
    repeat (8) @(negedge mclk);
  endtask
  // Strobes must have settled before the bit clock rises again
  initial begin
    forever begin
      @(negedge bit_clock);
      repeat (7) @(posedge mclk);
      if (exp_q.size() > 0)
        check({slot_active_n, rx_strobe, tx_strobe}, exp_q.pop_front());
    end
  end
  initial begin
    repeat (60000) @(posedge mclk);
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    summarize();
  end
  initial begin
    rst = 1'b1;
    mode1 = 1'b1;
    bit_clock = 1'b1;
    tx_frame = 1'b0;
    rx_frame = 1'b0;
    for (int i = 0; i < 4; i++) begin
      asg_tx[i] = tsa_pkg::SLOT_OFF;
      asg_rx[i] = tsa_pkg::SLOT_OFF;
    end
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    frame();
    for (int m = 0; m < 3; m++) begin
      mode1 = (m != 1);
      repeat (8) @(negedge mclk);
      for (int rd = 0; rd < 3; rd++) begin
        for (int c = 0; c < 8; c++) begin
          repeat (8) lfsr = lfsr_step(lfsr);
          r = lfsr[7:0];
          act = 2'(c + rd);
          // Mode 1 gets a random top select bit, which must be ignored
          ch = mode1 ? {r[6], 2'(c)} : 3'(c);
          if (!mode1 || c < 4) load({act, r[3], 2'h0, r[2:0]}, ch);
        end
        frame();
      end
    end
    summarize();
  end
endmodule
